// File: scp_regs.svh
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
// Purpose: Register offsets, field positions and reset values of the PWM block.
// Assumes: Wishbone byte addresses, one aligned 32-bit word per register.
// Notes: Bit positions follow the control register layout.
`define SCP_ADDR_DUTY 4'h0
`define SCP_ADDR_CTRL 4'h4
`define SCP_ADDR_PCTL 4'h8
`define SCP_ADDR_PDAT 4'hc
`define SCP_ADDR_STAT 4'h0
`define SCP_CTRL_MODE_BIT 5
`define SCP_CTRL_FUNC_BIT 3
`define SCP_PIN_BIT 4
`define SCP_DUTY_RST 8'h00
`define SCP_CTRL_RST 8'h00
`define SCP_PCTL_RST 8'hff
`define SCP_PDAT_RST 8'h00
`define SCP_SUB4_LEN 8'h40
`define SCP_SUB2_LEN 8'h80
`define SCP_PERIOD_LAST 8'hff
`endif

// File: scp_pkg.sv
// Purpose: Types shared by the PWM block.
// Assumes: Nothing beyond the register header.
// Notes: Types only.
package scp_pkg;
  typedef enum logic {SCP_MODE_SPLIT4, SCP_MODE_SPLIT2} scp_mode_e;
  typedef logic [7:0] scp_byte_t;
endpackage

// File: scp_wb_slave.sv
// Purpose: Classic Wishbone slave holding the software registers.
// Assumes: Single-cycle classic transfers, one ack per request.
// Notes: Ack comes one cycle after the request is seen and drops next cycle.
`include "scp_regs.svh"
module scp_wb_slave
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Register values and status
  input wire logic [7:0] pin_in_i,
  output logic [7:0] duty_o,
  output logic [7:0] ctrl_o,
  output logic [7:0] pctl_o,
  output logic [7:0] pdat_o
);
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [7:0] duty_reg, duty_next, ctrl_reg, ctrl_next;
  logic [7:0] pctl_reg, pctl_next, pdat_reg, pdat_next;
  logic wr;

  always_comb begin
    ack_next = cyc_i && stb_i && !ack_reg;
    wr = ack_next && we_i && sel_i[0];
    duty_next = duty_reg;
    ctrl_next = ctrl_reg;
    pctl_next = pctl_reg;
    pdat_next = pdat_reg;
    dat_next = 32'h0000_0000;
    if (wr) begin
      unique case (adr_i)
        `SCP_ADDR_DUTY: duty_next = dat_i[7:0];
        `SCP_ADDR_CTRL: ctrl_next = dat_i[7:0];
        `SCP_ADDR_PCTL: pctl_next = dat_i[7:0];
        `SCP_ADDR_PDAT: pdat_next = dat_i[7:0];
        default: ;
      endcase
    end
    if (ack_next && !we_i) begin
      unique case (adr_i)
        `SCP_ADDR_DUTY: dat_next = {24'h00_0000, duty_reg};
        `SCP_ADDR_CTRL: dat_next = {24'h00_0000, ctrl_reg};
        `SCP_ADDR_PCTL: dat_next = {24'h00_0000, pctl_reg};
        // Reading the data register returns the pin level, as a port does.
        `SCP_ADDR_PDAT: dat_next = {24'h00_0000, pin_in_i};
        default: dat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      duty_reg <= `SCP_DUTY_RST;
      ctrl_reg <= `SCP_CTRL_RST;
      pctl_reg <= `SCP_PCTL_RST;
      pdat_reg <= `SCP_PDAT_RST;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      duty_reg <= duty_next;
      ctrl_reg <= ctrl_next;
      pctl_reg <= pctl_next;
      pdat_reg <= pdat_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;
  assign duty_o = duty_reg;
  assign ctrl_o = ctrl_reg;
  assign pctl_o = pctl_reg;
  assign pdat_o = pdat_reg;
endmodule

// File: scp_pin_sync.sv
// Purpose: Three-stage synchroniser for the shared pin input.
// Assumes: Input is asynchronous to clk_i.
// Notes: The value changes only when the second and third stages agree.
module scp_pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] sh_reg, sh_next;
  logic lvl_reg, lvl_next;

  always_comb begin
    sh_next = {sh_reg[1:0], pin_i};
    lvl_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : lvl_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 3'h0;
      lvl_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level_o = lvl_reg;
endmodule

// File: scp_pwm_top.sv
// Purpose: Single-channel 8-bit sub-cycle PWM with a Wishbone register file.
// Assumes: 100 MHz clk_i, synchronous active-high reset.
// Notes: Duty and mode are taken only at a period boundary.
//
// What this block does
// (RULE1) Counter runs directly on system clock.
// (RULE2) Period 256 clocks, high total equals duty.
// (RULE3) Four-way mode: four 64-clock sub-cycles.
// (RULE4) Four-way: bits 7..2 base, 1..0 extra.
// (RULE5) Four-way: sub-cycle below extra gets base+1.
// (RULE6) Two-way mode: two 128-clock sub-cycles.
// (RULE7) Two-way: bits 7..1 base, bit 0 extra.
// (RULE8) Two-way: sub-cycle below extra gets base+1.
// (RULE9) Hardware splits sub-cycles without software help.
// (RULE10) Control bit 5 selects two-way mode.
// (RULE11) Control bit 3 gives pin 4 to PWM.
// (RULE12) Waveform reaches pin only when direction zero.
// (RULE13) Output-data bit one passes waveform, zero forces low.
// (RULE14) Direction one makes pin a plain input.
// (RULE15) High from sub-cycle start for count clocks.
// (RULE16) New duty and mode taken at period start.
`include "scp_regs.svh"
module scp_pwm_top
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Shared port pins
  input wire logic [7:0] port_i,
  output logic [7:0] port_o,
  output logic [7:0] port_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] duty_w, ctrl_w, pctl_w, pdat_w, pin_lvl;
  logic [31:0] dat_w;
  logic ack_w;

  scp_wb_slave u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .we_i(wb_we_i),
    .adr_i(wb_adr_i),
    .sel_i(wb_sel_i),
    .dat_i(wb_dat_i),
    .dat_o(dat_w),
    .ack_o(ack_w),
    .pin_in_i(pin_lvl),
    .duty_o(duty_w),
    .ctrl_o(ctrl_w),
    .pctl_o(pctl_w),
    .pdat_o(pdat_w)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_sync
      scp_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(port_i[g]),
        .level_o(pin_lvl[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] act_duty_reg, act_duty_next;
  scp_mode_e mode_reg, mode_next;
  logic wave_reg, wave_next;
  logic [7:0] base, sub_pos, sub_len, high;
  logic [1:0] sub_idx, extra;
  logic at_start;

  always_comb begin
    // The counter advances every clk_i edge, no prescaler. [RULE1]
    cnt_next = cnt_reg + 8'h01; // [RULE2]
    at_start = (cnt_reg == `SCP_PERIOD_LAST);
    act_duty_next = act_duty_reg;
    mode_next = mode_reg;
    // Latching at the boundary keeps a period from mixing two settings. [RULE16]
    if (at_start) begin
      act_duty_next = duty_w;
      mode_next = ctrl_w[`SCP_CTRL_MODE_BIT] ? SCP_MODE_SPLIT2 : SCP_MODE_SPLIT4; // [RULE10]
    end
    unique case (mode_next)
      SCP_MODE_SPLIT2: begin
        base = {1'b0, act_duty_next[7:1]}; // [RULE7]
        extra = {1'b0, act_duty_next[0]};
        sub_len = `SCP_SUB2_LEN; // [RULE6]
        sub_idx = {1'b0, cnt_next[7]};
        sub_pos = {1'b0, cnt_next[6:0]};
      end
      SCP_MODE_SPLIT4: begin
        base = {2'h0, act_duty_next[7:2]}; // [RULE4]
        extra = act_duty_next[1:0];
        sub_len = `SCP_SUB4_LEN; // [RULE3]
        sub_idx = cnt_next[7:6];
        sub_pos = {2'h0, cnt_next[5:0]};
      end
    endcase
    // Earlier sub-cycles take the extra clock. [RULE5] [RULE8] [RULE9]
    high = (sub_idx < extra) ? base + 8'h01 : base;
    // High from the sub-cycle start; high never exceeds sub_len. [RULE15]
    wave_next = (sub_pos < high) && (high <= sub_len);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= `SCP_PERIOD_LAST;
      act_duty_reg <= `SCP_DUTY_RST;
      mode_reg <= SCP_MODE_SPLIT4;
      wave_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_duty_reg <= act_duty_next;
      mode_reg <= mode_next;
      wave_reg <= wave_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] po_reg, po_next, oe_reg, oe_next;

  always_comb begin
    // Ordinary port bits: direction zero means output.
    oe_next = ~pctl_w; // [RULE12] [RULE14]
    po_next = pdat_w;
    // The data bit acts as the on/off gate of the waveform. [RULE11] [RULE13]
    if (ctrl_w[`SCP_CTRL_FUNC_BIT]) begin
      po_next[`SCP_PIN_BIT] = pdat_w[`SCP_PIN_BIT] & wave_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      po_reg <= `SCP_PDAT_RST;
      oe_reg <= 8'h00;
    end else begin
      po_reg <= po_next;
      oe_reg <= oe_next;
    end
  end

  // Ack and read data come straight from the slave's flip-flops; a second stage here
  // would let the slave take the still-held request again and ack it twice.
  assign wb_dat_o = dat_w;
  assign wb_ack_o = ack_w;
  assign port_o = po_reg;
  assign port_oe_o = oe_reg;
endmodule

// File: scp_load_model.sv
// Purpose: Load on the port pins with a pull-high on each line.
// Assumes: A released pin rests at the pull-high level.
// Notes: Pin levels only.
module scp_load_model (
  // Pins
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] pin_oe_i,
  output logic [7:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // An undriven pin never shows its stale value.
  assign lvl_o = (pin_o_i & pin_oe_i) | ~pin_oe_i;
endmodule

// File: scp_pwm_properties.sv
// Purpose: Port checks of the PWM block.
// Assumes: Synchronous active-high reset.
// Notes: Pin checks skip the cycles where a write moves the pins.
module scp_pwm_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] port_o,
  input wire logic [7:0] port_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr;
  assign wr = wb_cyc_i & wb_we_i;
  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_ack;
    !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence
  //////////////////////////////
  a_ack_timing: assert property (s_req |-> s_ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_oe_write: assert property ($changed(port_oe_o) |-> wr || $past(wr))
    else $error("enable moved without write");
  a_pin_write: assert property ($changed({port_o[7:5], port_o[3:0]}) |-> wr || $past(wr))
    else $error("port moved without write");
  a_rise_gap: assert property (disable iff (rst_i || wb_cyc_i)
    $rose(port_o[4]) && !$past(wr) && !$past(wr, 2) |=> !$rose(port_o[4]) [*8])
    else $error("rises too close");
  a_fall_gap: assert property (disable iff (rst_i || wb_cyc_i)
    $fell(port_o[4]) && !$past(wr) && !$past(wr, 2) |=> !$fell(port_o[4]) [*8])
    else $error("falls too close");
endmodule
bind scp_pwm_top scp_pwm_properties scp_pwm_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .port_o(port_o), .port_oe_o(port_oe_o));

// File: tb_top.sv
// Purpose: Self-checking bench for the sub-cycle PWM block.
// Assumes: Classic Wishbone master at 100 MHz.
// Notes: Runs are measured from a rise, so each pulse ends inside the window.
`include "scp_regs.svh"
module tb_top
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] po, poe, pin;
  int fails = 0, samples_checked = 0, hi, rs, mx, mn, b, x;
  scp_byte_t got;
  logic [3:0] ra[5] = '{`SCP_ADDR_DUTY, `SCP_ADDR_CTRL, `SCP_ADDR_PCTL, `SCP_ADDR_PDAT, 4'h2};
  scp_byte_t rv[5] = '{`SCP_DUTY_RST, `SCP_CTRL_RST, `SCP_PCTL_RST, 8'hff, 8'h00};
  bit md[6] = '{0, 0, 0, 1, 1, 1};
  scp_byte_t dv[6] = '{8'h07, 8'h40, 8'hf9, 8'h64, 8'h03, 8'hfd};
  scp_pwm_top scp_pwm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_i(pin), .port_o(po), .port_oe_o(poe));
  scp_load_model scp_load_model_inst (.pin_o_i(po), .pin_oe_i(poe), .lvl_o(pin));
  initial forever #5 clk_i = ~clk_i;
  //////////////////////////////
  task wb(input logic w, input logic [3:0] a, input scp_byte_t d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    got = rdat[7:0];
    if (n >= 50) fails++;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task meas(input bit sync);
    int run, n;
    hi = 0; rs = 0; mx = 0; mn = 999; run = 0; n = 0;
    while (sync && po[4] !== 1'b0 && n < 300) begin @(posedge clk_i); n++; end
    while (sync && po[4] !== 1'b1 && n < 600) begin @(posedge clk_i); n++; end
    if (n >= 600) fails++;
    repeat (256) begin
      if (po[4] === 1'b1) begin
        hi++;
        run++;
        if (run == 1) rs++;
      end else if (run > 0) begin
        mx = run > mx ? run : mx;
        mn = run < mn ? run : mn;
        run = 0;
      end
      @(posedge clk_i);
    end
  endtask
  task complete_run;
    $display("counts fails %0d checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[k]) begin
      wb(1'b0, ra[k], 8'h00);
      chk("reg", rv[k], got);
    end
    $display("test registers done");
    wb(1'b1, `SCP_ADDR_PCTL, 8'hef);
    wb(1'b1, `SCP_ADDR_PDAT, 8'h10);
    repeat (3) @(posedge clk_i);
    chk("oe", 1, poe[4]);
    foreach (md[k]) begin
      wb(1'b1, `SCP_ADDR_CTRL, md[k] ? 8'h28 : 8'h08);
      wb(1'b1, `SCP_ADDR_DUTY, dv[k]);
      repeat (600) @(posedge clk_i);
      meas(1'b1);
      b = md[k] ? dv[k] >> 1 : dv[k] >> 2;
      x = md[k] ? dv[k] & 1 : dv[k] & 3;
      chk("high", dv[k], hi);
      chk("subs", md[k] ? 2 : 4, rs);
      chk("max", b + (x != 0), mx);
      chk("min", b, mn);
      wb(1'b0, `SCP_ADDR_DUTY, 8'h00);
      chk("duty", dv[k], got);
    end
    $display("test waveform done");
    wb(1'b1, `SCP_ADDR_PDAT, 8'h00);
    repeat (10) @(posedge clk_i);
    meas(1'b0);
    chk("off", 0, hi);
    wb(1'b1, `SCP_ADDR_PDAT, 8'h10);
    wb(1'b1, `SCP_ADDR_CTRL, 8'h00);
    repeat (10) @(posedge clk_i);
    meas(1'b0);
    chk("plain", 256, hi);
    wb(1'b1, `SCP_ADDR_CTRL, 8'h08);
    wb(1'b1, `SCP_ADDR_PDAT, 8'h00);
    wb(1'b1, `SCP_ADDR_PCTL, 8'hff);
    repeat (10) @(posedge clk_i);
    chk("oe", 0, poe[4]);
    wb(1'b0, `SCP_ADDR_PDAT, 8'h00);
    chk("pin", 1, got[4]);
    $display("test pin control done");
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run;
  end
endmodule
